// File: logic/cecst_pkg.sv
// package: register map, flag layout, reset values and line timing of the cec status block
package cecst_pkg;

	// ==========================================================
	// clocking
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FS_HZ = 32_768;
	// low-speed sample tick: one pulse every FS_DIV system clocks
	localparam int unsigned FS_DIV = CLK_HZ / FS_HZ;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [5:0] A_TX_CONTROL = 6'h00;
	localparam logic [5:0] A_RX_STATUS = 6'h04;
	localparam logic [5:0] A_TX_STATUS = 6'h08;
	localparam logic [5:0] A_SAMPLE_SEL = 6'h0C;
	localparam logic [5:0] A_RX_CONTROL = 6'h10;
	localparam logic [5:0] A_TX_DATA = 6'h14;
	localparam logic [5:0] A_TX_CMD = 6'h18;
	localparam logic [5:0] A_RX_DATA = 6'h1C;
	localparam logic [5:0] A_RX_PEND = 6'h20;
	localparam logic [5:0] A_RX_MASK = 6'h24;
	localparam logic [5:0] A_TX_PEND = 6'h28;
	localparam logic [5:0] A_TX_MASK = 6'h2C;

	// ==========================================================
	// field positions
	localparam int unsigned TXC_BRD_BIT = 4;
	localparam int unsigned TXC_FREE_LSB = 0;
	localparam int unsigned SCS_SEL_BIT = 0;
	localparam int unsigned RXC_MIN_LSB = 0;
	localparam int unsigned RXC_MAX_LSB = 8;
	localparam int unsigned RXC_WAV_BIT = 16;
	localparam int unsigned RXC_ACK_BIT = 17;
	localparam int unsigned TXD_EOM_BIT = 8;
	localparam int unsigned TXD_FULL_BIT = 9;
	localparam int unsigned TXCMD_GO_BIT = 0;
	localparam int unsigned RXD_FULL_BIT = 10;

	// receive flags
	localparam int unsigned RX_FLAGS = 7;
	localparam int unsigned RX_WAV = 6;
	localparam int unsigned RX_OR = 5;
	localparam int unsigned RX_ACK = 4;
	localparam int unsigned RX_MIN = 3;
	localparam int unsigned RX_MAX = 2;
	localparam int unsigned RX_STA = 1;
	localparam int unsigned RX_END = 0;
	// transmit flags
	localparam int unsigned TX_FLAGS = 5;
	localparam int unsigned TX_UR = 4;
	localparam int unsigned TX_ACKE = 3;
	localparam int unsigned TX_AL = 2;
	localparam int unsigned TX_END = 1;
	localparam int unsigned TX_STA = 0;

	// ==========================================================
	// reset values
	localparam logic [3:0] TXC_FREE_RST = 4'h0;
	localparam logic [7:0] MIN_CYC_RST = 8'h43;
	localparam logic [7:0] MAX_CYC_RST = 8'h5A;

	// ==========================================================
	// line timing, in sample periods (1/fs)
	localparam logic [7:0] BIT_SAMPLES = 8'h4F;
	localparam logic [7:0] START_LOW = 8'h79;
	localparam logic [7:0] START_PERIOD = 8'h94;
	localparam logic [7:0] START_MIN = 8'h70;
	localparam logic [7:0] START_MAX = 8'h82;
	localparam logic [7:0] DATA1_LOW = 8'h14;
	localparam logic [7:0] DATA0_LOW = 8'h31;
	localparam logic [7:0] DATA_POINT = 8'h22;
	localparam logic [7:0] WAV_MAX = 8'h36;
	localparam logic [7:0] ACK_LOW = 8'h32;
	// index of the acknowledge bit within a block
	localparam logic [3:0] ACK_IDX = 4'h9;

	// transmit sequencer, gray along idle-free-low-high
	typedef enum logic [1:0] {
		CECST_IDLE = 2'b00,
		CECST_FREE = 2'b01,
		CECST_LOW = 2'b11,
		CECST_HIGH = 2'b10
	} cecst_tx_t;

endpackage : cecst_pkg

// File: logic/cecst_sample_tick.sv
// sample tick generator: low-speed divider or timer output edge
`timescale 1ns/1ns
`default_nettype none
module cecst_sample_tick
	import cecst_pkg::*;
#(
	parameter int unsigned DIV = FS_DIV
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sample_clock_sel,
	input wire logic timer_output_clock,
	output logic tick
);

	logic [11:0] div_cnt;
	logic timer_q;

	// free-running divider, always counting so a select change needs no restart
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 12'h000;
		end else if (div_cnt == 12'(DIV - 1)) begin
			div_cnt <= 12'h000;
		end else begin
			div_cnt <= div_cnt + 12'h001;
		end
	end

	// timer output is taken as synchronous; only its rising edge counts
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timer_q <= 1'b0;
			tick <= 1'b0;
		end else begin
			timer_q <= timer_output_clock;
			tick <= sample_clock_sel ? (timer_output_clock & ~timer_q)
				: (div_cnt == 12'(DIV - 1));
		end
	end

endmodule : cecst_sample_tick
`default_nettype wire

// File: logic/cecst_irq_bank.sv
// flag bank: clear-on-read status, write-one-clear pending, mask and irq
`timescale 1ns/1ns
`default_nettype none
module cecst_irq_bank #(
	parameter int unsigned W = 5
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [W-1:0] set,
	input wire logic rd_stat,
	input wire logic wr_pend,
	input wire logic wr_mask,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] stat,
	output logic [W-1:0] pend,
	output logic [W-1:0] mask,
	output logic irq
);

	// status ignores writes; a set in the reading cycle survives the clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stat <= '0;
		end else begin
			stat <= (stat & ~{W{rd_stat}}) | set;
		end
	end

	// pending bits feed the irq; set wins over a write-one clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend <= '0;
		end else begin
			pend <= (pend & ~(wr_pend ? wdata : {W{1'b0}})) | set;
		end
	end

	// mask resets open so every event raises the request by default
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask <= '1;
		end else if (wr_mask) begin
			mask <= wdata;
		end
	end

	assign irq = |(pend & mask);

endmodule : cecst_irq_bank
`default_nettype wire

// File: logic/cecst_top.sv
// cec status and transmit control: registers, line monitor, rx and tx engines
`timescale 1ns/1ns
`default_nettype none
// Operation
// - broadcast select set means the frame goes out as a broadcast
// - bus free field n asks for n+1 idle bit cycles, 1 to 16
// - transmission starts only after the line stayed idle that long
// - waveform error flag bit 6, only while waveform checking is enabled
// - overrun flag bit 5 when a byte lands on an unread one
// - ack collision flag bit 4 if line still low after our ack
// - minimum cycle flag bit 3 when a bit period is too short
// - maximum cycle flag bit 2 when a bit period is too long
// - start bit flag bit 1 on each recognised start bit
// - byte done flag bit 0 when a received byte completes
// - status registers are read only, upper bits read zero
// - underrun flag bit 4 when no next byte is ready in time
// - ack error flag bit 3 on missing zero, or missing broadcast one
// - arbitration lost flag bit 2 on low seen while releasing
// - transmit done flag bit 1 after the end-of-message byte
// - transmit start flag bit 0 when each byte starts
// - sample clock select 0 uses low-speed clock, 1 timer output
module cecst_top
	import cecst_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [5:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic timer_output_clock,
	input wire logic cec_in,
	output logic cec_out,
	output logic cec_oe_n,
	output logic rx_irq,
	output logic tx_irq
);

	// ==========================================================
	// helpers
	function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
		return a == off;
	endfunction : hit

	// idle time asked for, in samples
	function automatic logic [10:0] free_need(input logic [3:0] n);
		return 11'({7'h00, n} + 11'h001) * 11'({3'h0, BIT_SAMPLES});
	endfunction : free_need

	// ==========================================================
	// declarations
	logic broadcast_tx_sel;
	logic [3:0] bus_free_time;
	logic sample_clock_sel;
	logic wav_en;
	logic ack_en;
	logic [7:0] min_cyc;
	logic [7:0] max_cyc;
	logic [8:0] tx_buf;
	logic tx_full;
	logic [9:0] rx_buf;
	logic rx_full;
	logic tick;
	logic line_q;
	logic [7:0] low_cnt;
	logic [7:0] per_cnt;
	logic [10:0] high_cnt;
	logic fall;
	logic rise;
	cecst_tx_t st;
	logic [7:0] tcnt;
	logic [7:0] tnext;
	logic [9:0] tx_sh;
	logic [3:0] tx_bit;
	logic tx_start;
	logic tx_eom;
	logic [4:0] tx_ev;
	logic free_ok;
	logic bit_end;
	logic byte_end;
	logic tx_take;
	logic tx_go;
	logic [7:0] low_len;
	logic [7:0] period;
	logic rx_on;
	logic rx_act;
	logic rx_have;
	logic [3:0] rx_bit;
	logic [9:0] rx_sh;
	logic rx_store;
	logic [6:0] rx_ev;
	logic ack_drv;
	logic ack_chk;
	logic [7:0] ack_cnt;
	logic [6:0] rx_stat;
	logic [6:0] rx_pend;
	logic [6:0] rx_mask;
	logic [4:0] tx_stat;
	logic [4:0] tx_pend;
	logic [4:0] tx_mask;

	// ==========================================================
	// control registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			broadcast_tx_sel <= 1'b0;
			bus_free_time <= TXC_FREE_RST;
			sample_clock_sel <= 1'b0;
			wav_en <= 1'b0;
			ack_en <= 1'b0;
			min_cyc <= MIN_CYC_RST;
			max_cyc <= MAX_CYC_RST;
		end else if (wr_en) begin
			if (hit(addr, A_TX_CONTROL)) begin
				broadcast_tx_sel <= wdata[TXC_BRD_BIT];
				bus_free_time <= wdata[TXC_FREE_LSB +: 4];
			end
			if (hit(addr, A_SAMPLE_SEL)) begin
				sample_clock_sel <= wdata[SCS_SEL_BIT];
			end
			if (hit(addr, A_RX_CONTROL)) begin
				min_cyc <= wdata[RXC_MIN_LSB +: 8];
				max_cyc <= wdata[RXC_MAX_LSB +: 8];
				wav_en <= wdata[RXC_WAV_BIT];
				ack_en <= wdata[RXC_ACK_BIT];
			end
		end
	end

	// transmit holding buffer; a write in the taking cycle refills it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf <= 9'h000;
			tx_full <= 1'b0;
		end else if (wr_en && hit(addr, A_TX_DATA)) begin
			tx_buf <= wdata[8:0];
			tx_full <= 1'b1;
		end else if (tx_take) begin
			tx_full <= 1'b0;
		end
	end

	// receive buffer; a new byte in the reading cycle keeps it full
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_buf <= 10'h000;
			rx_full <= 1'b0;
		end else if (rx_store) begin
			rx_buf <= rx_sh;
			rx_full <= 1'b1;
		end else if (rd_en && hit(addr, A_RX_DATA)) begin
			rx_full <= 1'b0;
		end
	end

	// ==========================================================
	// sample clock and line monitor
	cecst_sample_tick #(
		.DIV(FS_DIV)
	) u_tick (
		.clock(clock),
		.rst_n(rst_n),
		.sample_clock_sel(sample_clock_sel),
		.timer_output_clock(timer_output_clock),
		.tick(tick)
	);

	assign fall = tick & line_q & ~cec_in;
	assign rise = tick & ~line_q & cec_in;

	// counters read before update give the length just ended
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= 1'b1;
			low_cnt <= 8'h00;
			per_cnt <= 8'h00;
			high_cnt <= 11'h000;
		end else if (tick) begin
			line_q <= cec_in;
			if (fall) begin
				low_cnt <= 8'h01;
				per_cnt <= 8'h01;
			end else begin
				if (!cec_in && low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
				if (per_cnt != 8'hFF) per_cnt <= per_cnt + 8'h01;
			end
			if (!cec_in) begin
				high_cnt <= 11'h000;
			end else if (high_cnt != 11'h7FF) begin
				high_cnt <= high_cnt + 11'h001;
			end
		end
	end

	// ==========================================================
	// transmit sequencer
	assign tnext = tcnt + 8'h01;
	assign tx_go = wr_en && hit(addr, A_TX_CMD) && wdata[TXCMD_GO_BIT] && (st == CECST_IDLE);
	assign free_ok = tick && (st == CECST_FREE) && (high_cnt >= free_need(bus_free_time));
	assign bit_end = tick && (st == CECST_HIGH) && (tnext >= period);
	assign byte_end = bit_end && !tx_start && (tx_bit == ACK_IDX);
	assign tx_take = tx_full && (free_ok || (byte_end && !tx_eom));
	// ack bit goes out as a one so receivers can pull it low
	assign low_len = tx_start ? START_LOW : (tx_sh[9] ? DATA1_LOW : DATA0_LOW);
	assign period = tx_start ? START_PERIOD : BIT_SAMPLES;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= CECST_IDLE;
			tcnt <= 8'h00;
			tx_sh <= 10'h000;
			tx_bit <= 4'h0;
			tx_start <= 1'b0;
			tx_eom <= 1'b0;
			tx_ev <= 5'h00;
		end else begin
			tx_ev <= 5'h00;
			case (st)
				CECST_IDLE: begin
					if (tx_go) st <= CECST_FREE;
				end
				CECST_FREE: begin
					if (free_ok && tx_full) begin
						st <= CECST_LOW;
						tcnt <= 8'h00;
						tx_start <= 1'b1;
						tx_sh <= {tx_buf[7:0], tx_buf[TXD_EOM_BIT], 1'b1};
						tx_eom <= tx_buf[TXD_EOM_BIT];
						tx_bit <= 4'h0;
						tx_ev[TX_STA] <= 1'b1;
					end else if (free_ok) begin
						st <= CECST_IDLE;
						tx_ev[TX_UR] <= 1'b1;
					end
				end
				CECST_LOW: begin
					if (tick) begin
						tcnt <= tnext;
						if (tnext >= low_len) st <= CECST_HIGH;
					end
				end
				CECST_HIGH: begin
					if (tick && !cec_in && (tx_start || tx_bit != ACK_IDX)) begin
						st <= CECST_IDLE;
						tx_ev[TX_AL] <= 1'b1;
					end else if (tick && !tx_start && tx_bit == ACK_IDX && tnext == DATA_POINT
						&& (broadcast_tx_sel ? !cec_in : cec_in)) begin
						st <= CECST_IDLE;
						tx_ev[TX_ACKE] <= 1'b1;
					end else if (byte_end) begin
						tcnt <= 8'h00;
						if (tx_eom) begin
							st <= CECST_IDLE;
							tx_ev[TX_END] <= 1'b1;
						end else if (tx_full) begin
							st <= CECST_LOW;
							tx_sh <= {tx_buf[7:0], tx_buf[TXD_EOM_BIT], 1'b1};
							tx_eom <= tx_buf[TXD_EOM_BIT];
							tx_bit <= 4'h0;
							tx_ev[TX_STA] <= 1'b1;
						end else begin
							st <= CECST_IDLE;
							tx_ev[TX_UR] <= 1'b1;
						end
					end else if (bit_end) begin
						tcnt <= 8'h00;
						st <= CECST_LOW;
						if (tx_start) begin
							tx_start <= 1'b0;
						end else begin
							tx_bit <= tx_bit + 4'h1;
							tx_sh <= {tx_sh[8:0], 1'b0};
						end
					end else if (tick) begin
						tcnt <= tnext;
					end
				end
				default: st <= CECST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// receive engine; own frames are not received back
	assign rx_on = (st == CECST_IDLE) || (st == CECST_FREE);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_act <= 1'b0;
			rx_have <= 1'b0;
			rx_bit <= 4'h0;
			rx_sh <= 10'h000;
			rx_store <= 1'b0;
			rx_ev <= 7'h00;
			ack_drv <= 1'b0;
			ack_chk <= 1'b0;
			ack_cnt <= 8'h00;
		end else begin
			rx_ev <= 7'h00;
			rx_store <= 1'b0;
			if (tick && rx_on) begin
				ack_chk <= 1'b0;
				// line must be back high one sample after our ack ends
				if (ack_chk && !cec_in) rx_ev[RX_ACK] <= 1'b1;
				if (ack_drv) begin
					if (ack_cnt == ACK_LOW) begin
						ack_drv <= 1'b0;
						ack_chk <= 1'b1;
					end else begin
						ack_cnt <= ack_cnt + 8'h01;
					end
				end else if (fall && rx_act && rx_bit == ACK_IDX && ack_en) begin
					ack_drv <= 1'b1;
					ack_cnt <= 8'h01;
				end
				if (rise && low_cnt >= START_MIN && low_cnt <= START_MAX) begin
					rx_act <= 1'b1;
					rx_have <= 1'b0;
					rx_bit <= 4'h0;
					rx_ev[RX_STA] <= 1'b1;
				end else if (rise && rx_act) begin
					if (wav_en && low_cnt > WAV_MAX) begin
						rx_act <= 1'b0;
						rx_ev[RX_WAV] <= 1'b1;
					end else begin
						rx_sh <= {rx_sh[8:0], (low_cnt < DATA_POINT)};
						rx_have <= 1'b1;
						if (rx_bit == ACK_IDX) begin
							rx_store <= 1'b1;
							rx_ev[RX_END] <= 1'b1;
							rx_ev[RX_OR] <= rx_full;
							rx_bit <= 4'h0;
							if (rx_sh[0]) rx_act <= 1'b0;
						end else begin
							rx_bit <= rx_bit + 4'h1;
						end
					end
				end else if (fall && rx_act && rx_have && per_cnt < min_cyc) begin
					rx_act <= 1'b0;
					rx_ev[RX_MIN] <= 1'b1;
				end else if (rx_act && rx_have && per_cnt > max_cyc) begin
					rx_act <= 1'b0;
					rx_ev[RX_MAX] <= 1'b1;
				end
			end
		end
	end

	// open-drain line: only ever pulls low
	assign cec_out = 1'b0;
	assign cec_oe_n = ~((st == CECST_LOW) | ack_drv);

	// ==========================================================
	// flag banks and interrupts
	cecst_irq_bank #(
		.W(RX_FLAGS)
	) u_rx_bank (
		.clock(clock),
		.rst_n(rst_n),
		.set(rx_ev),
		.rd_stat(rd_en && hit(addr, A_RX_STATUS)),
		.wr_pend(wr_en && hit(addr, A_RX_PEND)),
		.wr_mask(wr_en && hit(addr, A_RX_MASK)),
		.wdata(wdata[6:0]),
		.stat(rx_stat),
		.pend(rx_pend),
		.mask(rx_mask),
		.irq(rx_irq)
	);

	cecst_irq_bank #(
		.W(TX_FLAGS)
	) u_tx_bank (
		.clock(clock),
		.rst_n(rst_n),
		.set(tx_ev),
		.rd_stat(rd_en && hit(addr, A_TX_STATUS)),
		.wr_pend(wr_en && hit(addr, A_TX_PEND)),
		.wr_mask(wr_en && hit(addr, A_TX_MASK)),
		.wdata(wdata[4:0]),
		.stat(tx_stat),
		.pend(tx_pend),
		.mask(tx_mask),
		.irq(tx_irq)
	);

	// ==========================================================
	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= 32'h0000_0000;
			if (rd_en) begin
				case (addr)
					A_TX_CONTROL: begin
						rdata[TXC_BRD_BIT] <= broadcast_tx_sel;
						rdata[TXC_FREE_LSB +: 4] <= bus_free_time;
					end
					A_RX_STATUS: rdata[6:0] <= rx_stat;
					A_TX_STATUS: rdata[4:0] <= tx_stat;
					A_SAMPLE_SEL: rdata[SCS_SEL_BIT] <= sample_clock_sel;
					A_RX_CONTROL: begin
						rdata[RXC_MIN_LSB +: 8] <= min_cyc;
						rdata[RXC_MAX_LSB +: 8] <= max_cyc;
						rdata[RXC_WAV_BIT] <= wav_en;
						rdata[RXC_ACK_BIT] <= ack_en;
					end
					A_TX_DATA: begin
						rdata[8:0] <= tx_buf;
						rdata[TXD_FULL_BIT] <= tx_full;
					end
					A_TX_CMD: rdata[TXCMD_GO_BIT] <= (st != CECST_IDLE);
					A_RX_DATA: begin
						rdata[9:0] <= rx_buf;
						rdata[RXD_FULL_BIT] <= rx_full;
					end
					A_RX_PEND: rdata[6:0] <= rx_pend;
					A_RX_MASK: rdata[6:0] <= rx_mask;
					A_TX_PEND: rdata[4:0] <= tx_pend;
					A_TX_MASK: rdata[4:0] <= tx_mask;
					default: rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule : cecst_top
`default_nettype wire

// File: dv/cecst_monitor.sv
// checker: register reads, bus free wait and interrupt release at the top ports
`timescale 1ns/1ns
`default_nettype none
module cecst_monitor
	import cecst_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [5:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rdata,
	input wire logic timer_output_clock,
	input wire logic cec_in,
	input wire logic cec_out,
	input wire logic cec_oe_n,
	input wire logic rx_irq,
	input wire logic tx_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [4:0] txc_shadow;
	logic sel_shadow;
	logic armed;
	logic [15:0] idle;
	logic [15:0] free_min;

	// ==========================================================
	// shadow copies of the tx control and sample select fields
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txc_shadow <= 5'h00;
			sel_shadow <= 1'b0;
		end else if (wr_en && addr == A_TX_CONTROL) begin
			txc_shadow <= wdata[4:0];
		end else if (wr_en && addr == A_SAMPLE_SEL) begin
			sel_shadow <= wdata[0];
		end
	end
	// armed from a start command until the frame first drives the wire
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) armed <= 1'b0;
		else if (wr_en && addr == A_TX_CMD && wdata[0]) armed <= 1'b1;
		else if (!cec_oe_n) armed <= 1'b0;
	end
	// clocks since the wire was last low, saturating
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) idle <= 16'h0000;
		else if (!cec_in) idle <= 16'h0000;
		else if (idle != 16'hFFFF) idle <= idle + 16'h0001;
	end
	// fastest sampling is one sample per two clocks, so this is a safe floor
	assign free_min = (16'(txc_shadow[3:0]) + 16'h0001) * 16'h009E - 16'h0004;

	// ==========================================================
	// assertions
	sequence s_read(logic [5:0] a);
		rd_en && addr == a;
	endsequence
	AST_RDATA_IDLE: assert property (!rd_en |=> rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	AST_RX_UPPER: assert property (s_read(A_RX_STATUS) |=> rdata[31:7] == 25'h000_0000)
		else $error("rx status upper bits not zero");
	AST_TX_UPPER: assert property (s_read(A_TX_STATUS) |=> rdata[31:5] == 27'h000_0000)
		else $error("tx status upper bits not zero");
	AST_TXC_READ: assert property (s_read(A_TX_CONTROL) |=> rdata == {27'h000_0000, txc_shadow})
		else $error("tx control read differs from last write");
	AST_SEL_READ: assert property (s_read(A_SAMPLE_SEL) |=> rdata == {31'h0000_0000, sel_shadow})
		else $error("sample select read differs from last write");
	AST_BUS_FREE: assert property ($fell(cec_oe_n) && armed |-> idle >= free_min)
		else $error("frame began before the bus free time");
	AST_RX_IRQ_FALL: assert property ($fell(rx_irq) |-> $past(wr_en))
		else $error("rx irq dropped without a write");
	AST_TX_IRQ_FALL: assert property ($fell(tx_irq) |-> $past(wr_en))
		else $error("tx irq dropped without a write");
endmodule : cecst_monitor
bind cecst_top cecst_monitor mon (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
	.timer_output_clock, .cec_in, .cec_out, .cec_oe_n, .rx_irq, .tx_irq);
`default_nettype wire

// File: dv/cecst_peer.sv
// partner model: another device on the shared wire, sender and ack responder
`timescale 1ns/1ns
`default_nettype none
module cecst_peer (
	input wire logic clock,
	input wire logic cec_oe_n,
	output logic pull
);
	logic bit_low = 1'b0;
	logic oe_q = 1'b1;
	logic ack_on = 1'b0;
	logic arb_on = 1'b0;
	int falls = 0;
	int base = 0;
	int hold = 0;

	// ==========================================================
	// open wire: released means pulled up, so only lows are driven
	assign pull = bit_low || hold != 0;
	// count the device's falls in a frame; answer ack bit or collide
	always @(posedge clock) begin
		oe_q <= cec_oe_n;
		if (oe_q && !cec_oe_n) begin
			falls <= falls + 1;
			if (ack_on && falls - base == 10) hold <= 98; // ack zero for 49 samples
			if (arb_on && falls - base == 1) hold <= 140; // outlasts a one bit
		end else if (hold != 0) begin
			hold <= hold - 1;
		end
	end
	task automatic arm(input logic ack, input logic arb);
		// the counter has one writer; a frame counts from this base
		base <= falls;
		ack_on <= ack;
		arb_on <= arb;
	endtask : arm
	// one bit in samples, two clocks per sample
	task automatic send_bit(input int lo, input int per);
		@(posedge clock);
		bit_low <= 1'b1;
		repeat (lo * 2 - 1) @(posedge clock);
		bit_low <= 1'b0;
		repeat ((per - lo) * 2 - 1) @(posedge clock);
	endtask : send_bit
	task automatic send_byte(input logic [9:0] v);
		for (int i = 9; i >= 0; i--) send_bit(v[i] ? 20 : 49, 79);
	endtask : send_byte
endmodule : cecst_peer
`default_nettype wire

// File: dv/cec_status_and_tx_control_test.sv
// testbench: registers, receive flags, transmit flags and interrupts
`timescale 1ns/1ns
`default_nettype none
module cec_status_and_tx_control_test
	import cecst_pkg::*;
;
	logic clock, rst_n, wr_en, rd_en;
	logic timer_output_clock = 1'b0;
	logic cec_in, cec_out, cec_oe_n, rx_irq, tx_irq, pull;
	logic [5:0] addr;
	logic [31:0] wdata, rdata, got;
	int fails = 0;
	int check_count = 0;
	int idle = 0;

	// ==========================================================
	// wire, clocks and instances
	assign cec_in = !(pull || !cec_oe_n);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// timer output fast so a bit takes 158 clocks, not 241k
	always @(posedge clock) timer_output_clock <= ~timer_output_clock;
	always @(posedge clock) idle <= cec_in ? idle + 1 : 0;
	cecst_top dut (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
		.timer_output_clock, .cec_in, .cec_out, .cec_oe_n, .rx_irq, .tx_irq);
	cecst_peer peer (.clock, .cec_oe_n, .pull);

	// ==========================================================
	// bus and check helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic guard(input logic ok);
		if (ok !== 1'b1) begin
			fails++;
			$display("wrong value at %0t: wait ran out", $time);
			test_done();
		end
	endtask : guard
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		got = rdata;
		chk(got, e);
	endtask : rdchk

	// ==========================================================
	// scenarios
	task automatic regs_case;
		rdchk(A_TX_CONTROL, 32'h0000_0000);
		rdchk(A_SAMPLE_SEL, 32'h0000_0000);
		wr(A_RX_STATUS, 32'hFFFF_FFFF);
		wr(A_TX_STATUS, 32'hFFFF_FFFF);
		rdchk(A_RX_STATUS, 32'h0000_0000);
		rdchk(A_TX_STATUS, 32'h0000_0000);
		rdchk(6'h30, 32'h0000_0000);
		wr(A_TX_CONTROL, 32'hFFFF_FFFF);
		rdchk(A_TX_CONTROL, 32'h0000_001F);
		wr(A_SAMPLE_SEL, 32'h0000_0001);
		rdchk(A_SAMPLE_SEL, 32'h0000_0001);
	endtask : regs_case
	// two bytes, first left unread so the second overruns it
	task automatic rx_frame_case;
		peer.send_bit(121, 148);
		peer.send_byte(10'h169);
		peer.send_byte(10'h30F);
		repeat (20) @(negedge clock);
		chk(32'(rx_irq), 32'h0000_0001);
		rdchk(A_RX_STATUS, 32'h0000_0023);
		rdchk(A_RX_DATA, 32'h0000_070F);
		rdchk(A_RX_STATUS, 32'h0000_0000);
		wr(A_RX_PEND, 32'h0000_007F);
		@(negedge clock);
		chk(32'(rx_irq), 32'h0000_0000);
	endtask : rx_frame_case
	// one bad bit per row: short period, long period, long low
	task automatic rx_err_case;
		int lo [3] = '{20, 20, 60};
		int per [3] = '{40, 110, 79};
		logic [31:0] exp [3] = '{32'h0000_000A, 32'h0000_0006, 32'h0000_0042};
		for (int i = 0; i < 3; i++) begin
			wr(A_RX_CONTROL, i == 2 ? 32'h0001_5A43 : 32'h0000_5A43);
			if (i == 0) wr(A_RX_MASK, 32'h0000_0000);
			peer.send_bit(121, 148);
			peer.send_bit(20, 79);
			peer.send_bit(lo[i], per[i]);
			peer.send_bit(20, 79);
			repeat (20) @(posedge clock);
			rdchk(A_RX_STATUS, exp[i]);
			if (i == 0) begin
				chk(32'(rx_irq), 32'h0000_0000);
				wr(A_RX_MASK, 32'h0000_007F);
			end
			@(negedge clock);
			chk(32'(rx_irq), 32'h0000_0001);
			wr(A_RX_PEND, 32'h0000_007F);
		end
	endtask : rx_err_case
	// we ack the last block while the sender keeps the wire low too long
	task automatic ack_case;
		wr(A_RX_CONTROL, 32'h0002_5A43);
		peer.send_bit(121, 148);
		for (int i = 0; i < 9; i++) peer.send_bit(20, 79);
		peer.send_bit(60, 79);
		repeat (20) @(negedge clock);
		rdchk(A_RX_STATUS, 32'h0000_0013);
		rdchk(A_RX_DATA, 32'h0000_07FE);
		wr(A_RX_PEND, 32'h0000_007F);
	endtask : ack_case
	// rows: underrun, broadcast ok, directed no ack, collision, broadcast acked
	task automatic tx_case;
		logic [4:0] ctl [5] = '{5'h00, 5'h10, 5'h0F, 5'h00, 5'h10};
		logic [8:0] dat [5] = '{9'h0A5, 9'h1A5, 9'h1A5, 9'h1FF, 9'h1A5};
		logic [4:0] exp [5] = '{5'h11, 5'h03, 5'h09, 5'h04, 5'h08};
		logic [4:0] care [5] = '{5'h19, 5'h1B, 5'h19, 5'h04, 5'h08};
		int n;
		for (int i = 0; i < 5; i++) begin
			peer.arm(i == 0 || i == 4, i == 3);
			wr(A_TX_CONTROL, {27'h000_0000, ctl[i]});
			wr(A_TX_DATA, {23'h00_0000, dat[i]});
			wr(A_TX_CMD, 32'h0000_0001);
			for (n = 0; n < 6000 && cec_oe_n; n++) @(negedge clock);
			guard(!cec_oe_n);
			chk(32'(cec_out), 32'h0000_0000);
			chk(32'(idle >= (int'(ctl[i][3:0]) + 1) * 158 - 4), 32'h0000_0001);
			repeat (2) @(negedge clock);
			for (n = 0; n < 9000 && idle < 600; n++) @(negedge clock);
			guard(idle >= 600);
			rdchk(A_TX_CONTROL, {27'h000_0000, ctl[i]});
			@(posedge clock);
			rd_en <= 1'b1;
			addr <= A_TX_STATUS;
			@(posedge clock);
			rd_en <= 1'b0;
			@(negedge clock);
			chk(rdata & {27'h000_0000, care[i]}, {27'h000_0000, exp[i]});
			chk(32'(tx_irq), 32'h0000_0001);
			wr(A_TX_PEND, 32'h0000_001F);
			@(negedge clock);
			chk(32'(tx_irq), 32'h0000_0000);
		end
	endtask : tx_case

	// ==========================================================
	// verdict
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	// main sequence
	initial begin
		rst_n = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 6'h00;
		wdata = 32'h0000_0000;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		regs_case();
		rx_frame_case();
		rx_err_case();
		ack_case();
		tx_case();
		test_done();
	end
endmodule : cec_status_and_tx_control_test
`default_nettype wire
